//--- include/fail_mode_pkg.sv
// constants and types shared by the fail-mode supervisor
package fail_mode_pkg;
  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_KHZ = 40000;           // system clock rate in kHz
  localparam int unsigned WD_SHORT_MS = 32;          // watchdog, select bit low
  localparam int unsigned WD_LONG_MS = 128;          // watchdog, select bit high
  localparam int unsigned DGL_US = 200;              // fail-pin deglitch time
  localparam int unsigned WD_SHORT_CYC = WD_SHORT_MS * CLK_KHZ;
  localparam int unsigned WD_LONG_CYC = WD_LONG_MS * CLK_KHZ;
  localparam int unsigned DGL_CYC = (DGL_US * CLK_KHZ + 999) / 1000;

  // ****************************************
  // frame and status layout
  // ****************************************
  localparam int unsigned FRAME_BITS = 16;           // frame length granule
  localparam int unsigned EDGE_CNT_W = $clog2(FRAME_BITS);
  localparam int unsigned NUM_POWER = 5;             // power channels
  localparam int unsigned NUM_DIRECT = 4;            // direct control pins
  localparam int unsigned NUM_FAULT = 8;             // reported fault kinds
  localparam int unsigned STAT_W = 8;                // status register 7 width
  localparam int unsigned STAT_FAIL_PIN = 0;         // fail pin level
  localparam int unsigned STAT_SERIAL_FAULT = 1;     // serial fault flag
  localparam int unsigned STAT_FAIL_MODE = 2;        // in fail mode
  localparam int unsigned STAT_FILTERED = 3;         // filtered fail request
  localparam logic [STAT_W-1:0] STAT_RESET = 8'h00;
  localparam logic [NUM_FAULT-1:0] FAULT_RESET = 8'h00;

  // ****************************************
  // fault kind positions
  // ****************************************
  localparam int unsigned FLT_OPEN_LOAD = 0;
  localparam int unsigned FLT_SHORT_BAT = 1;
  localparam int unsigned FLT_SHORT_GND = 2;
  localparam int unsigned FLT_OVERCURRENT = 3;
  localparam int unsigned FLT_OVERTEMP = 4;
  localparam int unsigned FLT_CLOCK_FAIL = 5;
  localparam int unsigned FLT_UNDERVOLT = 6;
  localparam int unsigned FLT_OVERVOLT = 7;

  typedef enum logic {MODE_NORMAL, MODE_FAIL} mode_t;
endpackage

//--- design/fail_mode_supervisor.sv
// fail-mode supervisor: wake report, supply loss, link checks, fail mode
// ****************************************
// Overview of operation
// - clock pin reports wake only while release low
// - awake and not released-woken: drive clock pin high
// - sleep or release wake: clock pin stays input
// - both supplies lost: all off, all cleared
// - battery lost: keep state, channels off, ext follows
// - battery lost: no wake report on clock pin
// - logic supply lost: frames ignored, watchdog expires
// - normal mode: channels follow PWM generator
// - report eight fault kinds to serial side
// - fail pin high enters fail mode
// - fail mode: channels 0-3 follow direct pins, channel 4 off
// - status 7 shows fail pin level
// - untoggled frame bit is a link fault
// - watchdog expiry is a link fault
// - edges not multiple of 16: link fault
// - stuck data caught by toggle check
// - link fault sets flag in status 7
// - flag held while in fail mode
// - flag cleared on fail-to-normal move
// - select bit picks 32 or 128 ms timeout
// - fail pin acted on after 200 us high
// ****************************************
module fail_mode_supervisor
  import fail_mode_pkg::*;
#(
  parameter int unsigned WD_SHORT = WD_SHORT_CYC,
  parameter int unsigned WD_LONG = WD_LONG_CYC,
  parameter int unsigned DGL = DGL_CYC
) (
  // system clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // serial link, clocked by the host
  input wire logic link_clk_in,
  input wire logic cs_n_in,
  input wire logic si_in,
  // bidirectional clock pin, wake report side
  output logic clk_pin_out,
  output logic clk_pin_oe_n_out,
  // wake and supply state
  input wire logic chip_release_input_n_in,
  input wire logic wake_in,
  input wire logic wake_by_release_in,
  input wire logic bat_ok_in,
  input wire logic vcc_ok_in,
  // mode control
  input wire logic fail_pin_in,
  input wire logic timeout_select_bit_in,
  input wire logic fail_exit_req_in,
  // channel sources
  input wire logic [NUM_POWER-1:0] pwm_channel_in,
  input wire logic [NUM_DIRECT-1:0] direct_channel_inputs_in,
  input wire logic ext_cfg_in,
  // fault sources and clear
  input wire logic [NUM_FAULT-1:0] fault_kinds_in,
  input wire logic fault_clear_in,
  // channel drives
  output logic [NUM_POWER-1:0] power_channel_outputs_out,
  output logic external_switch_drive_out,
  // status
  output logic [STAT_W-1:0] status7_out,
  output logic [NUM_FAULT-1:0] fault_report_out,
  output logic fail_mode_out
);

  // ****************************************
  // link domain
  // ****************************************
  logic [EDGE_CNT_W-1:0] edge_cnt;
  logic in_frame;
  logic frame_toggle;
  logic link_frame_rstn;

  // in_frame drops as soon as chip select goes high
  assign link_frame_rstn = rstn_in & ~cs_n_in;

  // edge count modulo 16, kept across frames
  always_ff @(posedge link_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      edge_cnt <= '0;
    end else if (!cs_n_in) begin
      edge_cnt <= edge_cnt + 1'b1;
    end
  end

  // first edge of frame marker
  always_ff @(posedge link_clk_in or negedge link_frame_rstn) begin
    if (!link_frame_rstn) begin
      in_frame <= 1'b0;
    end else begin
      in_frame <= 1'b1;
    end
  end

  // toggle bit is the first bit of each frame
  always_ff @(posedge link_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      frame_toggle <= 1'b0;
    end else if (!cs_n_in && !in_frame) begin
      frame_toggle <= si_in;
    end
  end

  // ****************************************
  // pin synchronisers
  // ****************************************
  localparam int unsigned NSYNC = 7;
  logic [NSYNC-1:0] sync_a;
  logic [NSYNC-1:0] sync_b;
  logic cs_n_s, release_n_s, wake_s, wake_rel_s, bat_s, vcc_s, fail_pin_s;

  // two flops per pin before any logic
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sync_a <= 7'h01;
      sync_b <= 7'h01;
    end else begin
      sync_a <= {fail_pin_in, vcc_ok_in, bat_ok_in, wake_by_release_in, wake_in,
                 chip_release_input_n_in, cs_n_in};
      sync_b <= sync_a;
    end
  end

  assign {fail_pin_s, vcc_s, bat_s, wake_rel_s, wake_s, release_n_s, cs_n_s} = sync_b;

  // ****************************************
  // supply state
  // ****************************************
  logic power_off;
  assign power_off = ~bat_s & ~vcc_s;

  // ****************************************
  // wake report on the clock pin
  // ****************************************
  logic report_wake;
  assign report_wake = ~release_n_s & wake_s & ~wake_rel_s & bat_s;

  // drive high when reporting, else leave as input
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      clk_pin_out <= 1'b0;
      clk_pin_oe_n_out <= 1'b1;
    end else begin
      clk_pin_out <= report_wake;
      clk_pin_oe_n_out <= ~report_wake;
    end
  end

  // ****************************************
  // fail pin deglitch
  // ****************************************
  localparam int unsigned DGL_W = $clog2(DGL + 1);
  logic [DGL_W-1:0] dgl_cnt;
  logic filtered_fail_request;

  // request rises only after the pin stayed high long enough
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      dgl_cnt <= '0;
      filtered_fail_request <= 1'b0;
    end else if (power_off || !fail_pin_s) begin
      dgl_cnt <= '0;
      filtered_fail_request <= 1'b0;
    end else if (dgl_cnt == DGL_W'(DGL)) begin
      filtered_fail_request <= 1'b1;
    end else begin
      dgl_cnt <= dgl_cnt + 1'b1;
    end
  end

  // ****************************************
  // frame end checks
  // ****************************************
  logic cs_n_d;
  logic frame_end;
  logic [EDGE_CNT_W-1:0] last_cnt;
  logic last_toggle;
  logic good_frame;
  logic bad_frame;

  // link regs are still while chip select is high
  assign frame_end = cs_n_s & ~cs_n_d & vcc_s;
  assign good_frame = frame_end && edge_cnt == last_cnt && frame_toggle != last_toggle;
  assign bad_frame = frame_end & ~good_frame;

  // remember count and toggle of the last frame
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cs_n_d <= 1'b1;
      last_cnt <= '0;
      last_toggle <= 1'b0;
    end else begin
      cs_n_d <= cs_n_s;
      if (power_off) begin
        last_cnt <= edge_cnt; // link counter keeps its residue, stay aligned to it
        last_toggle <= 1'b0;
      end else if (frame_end) begin
        last_cnt <= edge_cnt;
        last_toggle <= frame_toggle;
      end
    end
  end

  // ****************************************
  // watchdog
  // ****************************************
  localparam int unsigned WD_W = $clog2(WD_LONG + 1);
  logic [WD_W-1:0] wd_cnt;
  logic [WD_W-1:0] wd_limit;
  logic wd_expire;

  assign wd_limit = timeout_select_bit_in ? WD_W'(WD_LONG) : WD_W'(WD_SHORT);
  assign wd_expire = wd_cnt >= wd_limit;

  // restart on good frame, else count towards expiry
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wd_cnt <= '0;
    end else if (power_off || good_frame || wd_expire) begin
      wd_cnt <= '0;
    end else begin
      wd_cnt <= wd_cnt + 1'b1;
    end
  end

  // ****************************************
  // mode and serial fault flag
  // ****************************************
  mode_t mode;
  logic link_fault;
  logic serial_fault_flag;

  assign link_fault = bad_frame | wd_expire;

  // fail entry wins over an exit request
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mode <= MODE_NORMAL;
    end else if (power_off) begin
      mode <= MODE_NORMAL;
    end else begin
      unique case (mode)
        MODE_NORMAL: begin
          if (filtered_fail_request || link_fault) begin
            mode <= MODE_FAIL;
          end
        end
        MODE_FAIL: begin
          if (fail_exit_req_in && !filtered_fail_request && !link_fault) begin
            mode <= MODE_NORMAL;
          end
        end
      endcase
    end
  end

  // flag set by link faults, held in fail mode, cleared on exit
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      serial_fault_flag <= 1'b0;
    end else if (power_off) begin
      serial_fault_flag <= 1'b0;
    end else if (link_fault) begin
      serial_fault_flag <= 1'b1;
    end else if (mode == MODE_FAIL && fail_exit_req_in && !filtered_fail_request) begin
      serial_fault_flag <= 1'b0;
    end else begin
      serial_fault_flag <= serial_fault_flag;
    end
  end

  // ****************************************
  // fault latches and status
  // ****************************************
  // sticky faults, a new fault wins over the clear
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      fault_report_out <= FAULT_RESET;
    end else if (power_off) begin
      fault_report_out <= FAULT_RESET;
    end else if (fault_clear_in) begin
      fault_report_out <= fault_kinds_in;
    end else begin
      fault_report_out <= fault_report_out | fault_kinds_in;
    end
  end

  // status register 7 image
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      status7_out <= STAT_RESET;
    end else begin
      status7_out <= STAT_RESET;
      status7_out[STAT_FAIL_PIN] <= fail_pin_s;
      status7_out[STAT_SERIAL_FAULT] <= serial_fault_flag;
      status7_out[STAT_FAIL_MODE] <= mode == MODE_FAIL;
      status7_out[STAT_FILTERED] <= filtered_fail_request;
    end
  end

  // ****************************************
  // channel drives
  // ****************************************
  logic [NUM_DIRECT-1:0] direct_a;
  logic [NUM_DIRECT-1:0] direct_s;
  logic [NUM_POWER-1:0] next_power;

  // direct pins come from outside, two flops before any logic
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      direct_a <= '0;
      direct_s <= '0;
    end else begin
      direct_a <= direct_channel_inputs_in;
      direct_s <= direct_a;
    end
  end

  // per channel source select
  generate
    for (genvar i = 0; i < NUM_POWER; i++) begin : g_ch
      if (i < NUM_DIRECT) begin : g_dir
        assign next_power[i] = (mode == MODE_FAIL) ? direct_s[i]
                                                   : pwm_channel_in[i];
      end else begin : g_pwm
        assign next_power[i] = (mode == MODE_FAIL) ? 1'b0 : pwm_channel_in[i];
      end
    end
  endgenerate

  // battery loss turns power channels off, ext keeps its config
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      power_channel_outputs_out <= '0;
      external_switch_drive_out <= 1'b0;
      fail_mode_out <= 1'b0;
    end else begin
      power_channel_outputs_out <= bat_s ? next_power : '0;
      external_switch_drive_out <= vcc_s & ext_cfg_in & (mode == MODE_NORMAL);
      fail_mode_out <= mode == MODE_FAIL;
    end
  end

endmodule

//--- tb/fms_chk.sv
// assertions on the fail-mode supervisor ports
// ****************************************
// port checker
// ****************************************
module fms_chk
  import fail_mode_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // watched inputs
  input wire logic chip_release_input_n_in,
  input wire logic bat_ok_in,
  input wire logic [NUM_DIRECT-1:0] direct_channel_inputs_in,
  input wire logic [NUM_POWER-1:0] pwm_channel_in,
  // watched outputs
  input wire logic clk_pin_out,
  input wire logic clk_pin_oe_n_out,
  input wire logic [NUM_POWER-1:0] power_channel_outputs_out,
  input wire logic [STAT_W-1:0] status7_out,
  input wire logic fail_mode_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  // settled mode windows with battery present
  sequence s_fail_steady; (bat_ok_in && fail_mode_out)[*5]; endsequence
  sequence s_norm_steady; (bat_ok_in && !fail_mode_out)[*5]; endsequence
  property p_drive_high; !clk_pin_oe_n_out |-> clk_pin_out; endproperty
  a_drive_high: assert property (p_drive_high) else $error("pin driven low");
  property p_release_quiet; chip_release_input_n_in[*4] |-> clk_pin_oe_n_out; endproperty
  a_release_quiet: assert property (p_release_quiet) else $error("pin driven");
  property p_bat_no_wake; !bat_ok_in[*4] |-> clk_pin_oe_n_out; endproperty
  a_bat_no_wake: assert property (p_bat_no_wake) else $error("wake shown");
  property p_filt_enter; status7_out[STAT_FILTERED] && bat_ok_in |=> fail_mode_out; endproperty
  a_filt_enter: assert property (p_filt_enter) else $error("no fail mode");
  property p_flag_in_fail; status7_out[STAT_SERIAL_FAULT] |-> fail_mode_out; endproperty
  a_flag_in_fail: assert property (p_flag_in_fail) else $error("flag outside");
  property p_flag_hold;
    status7_out[STAT_SERIAL_FAULT] && fail_mode_out
      |=> status7_out[STAT_SERIAL_FAULT] || !fail_mode_out;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag lost");
  property p_flag_clear; $fell(fail_mode_out) |-> !status7_out[STAT_SERIAL_FAULT]; endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag kept");
  property p_direct;
    s_fail_steady |-> power_channel_outputs_out == {1'h0, $past(direct_channel_inputs_in, 3)};
  endproperty
  a_direct: assert property (p_direct) else $error("channels not direct");
  property p_pwm; s_norm_steady |-> power_channel_outputs_out == $past(pwm_channel_in); endproperty
  a_pwm: assert property (p_pwm) else $error("channels not pwm");
endmodule
bind fail_mode_supervisor fms_chk i_fms_chk (.*);

//--- tb/host_link.sv
// host side of the serial link, clock stands still between frames
module host_link (
  // serial lines
  output logic link_clk_out,
  output logic cs_n_out,
  output logic si_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic toggle_bit = 1'h0;
  initial begin
    link_clk_out = 1'h0;
    cs_n_out = 1'h1;
    si_out = 1'h1;
  end
  // one frame of nbits edges; keep repeats the previous toggle value
  task automatic send_frame(input int nbits, input bit keep);
    #9;
    if (!keep) toggle_bit = ~toggle_bit;
    cs_n_out = 1'h0;
    for (int i = 0; i < nbits; i++) begin
      si_out = (i == 0) ? toggle_bit : i[0];
      #32 link_clk_out = 1'h1;
      #32 link_clk_out = 1'h0;
    end
    #32 cs_n_out = 1'h1;
    si_out = ~si_out; // released line shows no stale bit
  endtask
endmodule

//--- tb/tb_top.sv
// self-checking bench for the fail-mode supervisor
module tb_top;
  import fail_mode_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in, rstn_in = 1'h0, link_clk_in, cs_n_in, si_in, clk_pin_out, clk_pin_oe_n_out;
  logic chip_release_input_n_in = 1'h1, wake_in = 1'h1, wake_by_release_in = 1'h0;
  logic bat_ok_in = 1'h1, vcc_ok_in = 1'h1, fail_pin_in = 1'h0, timeout_select_bit_in = 1'h1;
  logic fail_exit_req_in = 1'h0, ext_cfg_in = 1'h1, fault_clear_in = 1'h0;
  logic [4:0] pwm_channel_in = 5'h00, power_channel_outputs_out;
  logic [3:0] direct_channel_inputs_in = 4'h0;
  logic [7:0] fault_kinds_in = 8'h00, fault_report_out, status7_out;
  logic external_switch_drive_out, fail_mode_out;
  int bad_count = 0, tests_run = 0;
  // clock pin rows: release_n wake by_release bat_ok | drive oe_n
  logic [5:0] rows [5] = '{6'h16, 6'h35, 6'h05, 6'h1D, 6'h11};
  fail_mode_supervisor #(.WD_SHORT(200), .WD_LONG(800), .DGL(20)) i_fail_mode_supervisor (.*);
  host_link i_host_link (.link_clk_out(link_clk_in), .cs_n_out(cs_n_in), .si_out(si_in));
  initial begin
    clk_in = 1'h0;
    forever #12.5 clk_in = ~clk_in;
  end
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic frame(input int n, input bit keep);
    i_host_link.send_frame(n, keep);
    cyc(6);
  endtask
  // two frames so a stale toggle value cannot block the exit
  task automatic recover;
    frame(16, 0);
    frame(16, 0);
    fail_exit_req_in <= 1'h1;
    cyc(1);
    fail_exit_req_in <= 1'h0;
    cyc(4);
  endtask
  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    cyc(10);
    chk("oe_n in reset", 8'(clk_pin_oe_n_out), 8'h01);
    rstn_in <= 1'h1;
    cyc(3);
    foreach (rows[i]) begin
      {chip_release_input_n_in, wake_in, wake_by_release_in, bat_ok_in} <= rows[i][5:2];
      cyc(5);
      chk("pin", 8'({clk_pin_out, clk_pin_oe_n_out}), 8'(rows[i][1:0]));
    end
    bat_ok_in <= 1'h1;
    recover;
    chk("mode after exit", 8'(fail_mode_out), 8'h00);
    chk("status", status7_out, 8'h00);
    pwm_channel_in <= 5'h15;
    fault_kinds_in <= 8'h81;
    cyc(1);
    fault_kinds_in <= 8'h00;
    cyc(3);
    chk("pwm drive", 8'(power_channel_outputs_out), 8'h15);
    chk("faults", fault_report_out, 8'h81);
    // clear and a new fault in one cycle: the new fault stays
    fault_clear_in <= 1'h1;
    fault_kinds_in <= 8'h04;
    cyc(1);
    fault_clear_in <= 1'h0;
    fault_kinds_in <= 8'h00;
    cyc(2);
    chk("fault clear", fault_report_out, 8'h04);
    frame(15, 0);
    chk("flag", 8'(status7_out[STAT_SERIAL_FAULT]), 8'h01);
    direct_channel_inputs_in <= 4'hA;
    cyc(30);
    chk("direct drive", 8'(power_channel_outputs_out), 8'h0A);
    recover;
    frame(16, 1);
    chk("mode", 8'(fail_mode_out), 8'h01);
    timeout_select_bit_in <= 1'h0;
    recover;
    cyc(150);
    chk("mode", 8'(fail_mode_out), 8'h00);
    cyc(60);
    chk("mode", 8'(fail_mode_out), 8'h01);
    timeout_select_bit_in <= 1'h1;
    recover;
    cyc(700);
    chk("mode", 8'(fail_mode_out), 8'h00);
    vcc_ok_in <= 1'h0;
    frame(16, 0);
    cyc(120);
    chk("mode", 8'(fail_mode_out), 8'h01);
    vcc_ok_in <= 1'h1;
    recover;
    bat_ok_in <= 1'h0;
    cyc(5);
    chk("channels", 8'(power_channel_outputs_out), 8'h00);
    chk("ext drive", 8'(external_switch_drive_out), 8'h01);
    chk("faults", fault_report_out, 8'h04);
    bat_ok_in <= 1'h1;
    fail_pin_in <= 1'h1;
    cyc(5);
    chk("pin level", 8'(status7_out[STAT_FAIL_PIN]), 8'h01);
    chk("mode", 8'(fail_mode_out), 8'h00);
    cyc(25);
    chk("mode", 8'(fail_mode_out), 8'h01);
    fail_pin_in <= 1'h0;
    {bat_ok_in, vcc_ok_in} <= 2'h0;
    cyc(6);
    chk("off status", status7_out, 8'h00);
    chk("off faults", fault_report_out, 8'h00);
    chk("off mode", 8'(fail_mode_out), 8'h00);
    report_and_stop;
  end
  // cut a hang short
  initial begin
    #150000;
    bad_count++;
    report_and_stop;
  end
endmodule
